/* rtl/dps_host_map.svh */
// Register map, field positions, reset values and pin timing of the port controller.
// Included by the controller modules; holds definitions only.
`ifndef DPS_HOST_MAP_SVH
`define DPS_HOST_MAP_SVH

// Clock period and device pin timing, in ns
`define DPS_CLK_NS        8
`define DPS_T_ACC_NS      55
`define DPS_T_BSET_NS     20
`define DPS_T_REC_NS      10

// Register byte offsets
`define DPS_OFF_CTRL      8'h00
`define DPS_OFF_CMD       8'h04
`define DPS_OFF_ADDR      8'h08
`define DPS_OFF_WDATA     8'h0C
`define DPS_OFF_RDATA     8'h10
`define DPS_OFF_STATUS    8'h14

// CTRL fields
`define DPS_CTRL_ROLE     0
`define DPS_CTRL_INHIBIT  1
`define DPS_CTRL_RESET    2'h0

// STATUS fields
`define DPS_ST_ACTIVE     0
`define DPS_ST_DONE       1
`define DPS_ST_GRANT      2
`define DPS_ST_REFUSED    3
`define DPS_ST_MAIL       4
`define DPS_ST_STALLED    5
`define DPS_ST_MIXED      6

// Device address space
`define DPS_MBX_TO_LEFT   12'hFFE
`define DPS_MBX_TO_RIGHT  12'hFFF
`define DPS_SEM_LAST      3'h7

`endif

/* rtl/dps_host_pkg.sv */
// Types shared by the port controller modules.
// Assumes nothing of its surroundings.
package dps_host_pkg;

  // Commands written to CMD
  typedef enum logic [2:0] {
    OP_MEM_RD, OP_MEM_WR, OP_SEM_CLAIM, OP_SEM_RELEASE,
    OP_SEM_READ, OP_SEM_INIT, OP_MAIL_SEND, OP_MAIL_TAKE
  } host_op_e;

  // Pin sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_SETUP, SQ_STROBE, SQ_RECOVER} seq_state_e;

  // Command engine states
  typedef enum logic {MS_IDLE, MS_WAIT} main_state_e;

endpackage : dps_host_pkg

/* rtl/dps_pin_seq.sv */
// One access cycle on a port of the two-port memory: setup, strobe, recovery.
// Assumes the device pins are sampled synchronously to sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "dps_host_map.svh"

module dps_pin_seq #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic          start_i,
  input  wire logic          sem_i,
  input  wire logic          write_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          busy_ok_i,
  input  wire logic [DW-1:0] dq_i,
  output logic               done_o,
  output logic [DW-1:0]      rdata_o,
  output logic               stalled_o,
  output logic               port_select_n_o,
  output logic               sem_select_n_o,
  output logic               out_enable_n_o,
  output logic               write_not_read_o,
  output logic [1:0]         byte_en_n_o,
  output logic [AW-1:0]      addr_o,
  output logic [DW-1:0]      dq_o,
  output logic               dq_oe_n_o
);

  // Least times round up to whole cycles
  localparam int SET_CYC = (`DPS_T_BSET_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS;
  localparam int ACC_CYC = (`DPS_T_ACC_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS;
  localparam int REC_CYC = (`DPS_T_REC_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS;

  dps_host_pkg::seq_state_e state_q;
  logic [3:0]               cnt_q;
  logic                     wr_q;

  // Access sequence; every pin comes from a flop
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q          <= dps_host_pkg::SQ_IDLE;
      cnt_q            <= 4'h0;
      wr_q             <= 1'b0;
      done_o           <= 1'b0;
      rdata_o          <= '0;
      stalled_o        <= 1'b0;
      port_select_n_o  <= 1'b1;
      sem_select_n_o   <= 1'b1;
      out_enable_n_o   <= 1'b1;
      write_not_read_o <= 1'b1;
      byte_en_n_o      <= 2'h3;
      addr_o           <= '0;
      dq_o             <= '0;
      dq_oe_n_o        <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        dps_host_pkg::SQ_IDLE: begin
          if (start_i) begin
            // Semaphore space: memory select high, semaphore select low
            port_select_n_o <= sem_i;
            sem_select_n_o  <= ~sem_i;
            addr_o          <= sem_i ? {{(AW-3){1'b0}}, addr_i[2:0]} : addr_i;
            dq_o            <= sem_i ? {{(DW-1){1'b0}}, wdata_i[0]} : wdata_i;
            dq_oe_n_o       <= ~write_i;
            wr_q            <= write_i;
            stalled_o       <= 1'b0;
            cnt_q           <= 4'(SET_CYC - 1);
            state_q         <= dps_host_pkg::SQ_SETUP;
          end
        end
        dps_host_pkg::SQ_SETUP: begin
          // Address and select settle before any strobe; stall while busy
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (!busy_ok_i) begin
            stalled_o <= 1'b1;
          end else begin
            write_not_read_o <= ~wr_q;
            out_enable_n_o   <= wr_q;
            byte_en_n_o      <= 2'h0;
            stalled_o        <= 1'b0;
            cnt_q            <= 4'(ACC_CYC - 1);
            state_q          <= dps_host_pkg::SQ_STROBE;
          end
        end
        dps_host_pkg::SQ_STROBE: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            rdata_o          <= dq_i;
            write_not_read_o <= 1'b1;
            out_enable_n_o   <= 1'b1;
            byte_en_n_o      <= 2'h3;
            cnt_q            <= 4'(REC_CYC - 1);
            state_q          <= dps_host_pkg::SQ_RECOVER;
          end
        end
        dps_host_pkg::SQ_RECOVER: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            // Deselect so the port drops to standby
            port_select_n_o <= 1'b1;
            sem_select_n_o  <= 1'b1;
            dq_oe_n_o       <= 1'b1;
            done_o          <= 1'b1;
            state_q         <= dps_host_pkg::SQ_IDLE;
          end
        end
        default: state_q <= dps_host_pkg::SQ_IDLE;
      endcase
    end
  end

endmodule : dps_pin_seq
`default_nettype wire

/* rtl/dps_host_ctrl.sv */
// Controller for one port of a two-port memory with mailbox, busy and semaphores.
// Assumes an APB master on sys_clk_i and device pins synchronous to that clock.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dps_host_map.svh"

module dps_host_ctrl #(
  parameter bit IS_LEFT = 1'b1,
  parameter int NBUSY   = 1,
  parameter int AW      = 12,
  parameter int DW      = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // APB slave
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // Device port pins
  output logic                  port_select_n_o,
  output logic                  sem_select_n_o,
  output logic                  out_enable_n_o,
  output logic                  write_not_read_o,
  output logic [1:0]            byte_en_n_o,
  output logic [AW-1:0]         addr_o,
  input  wire logic [DW-1:0]    dq_i,
  output logic [DW-1:0]         dq_o,
  output logic                  dq_oe_n_o,
  input  wire logic [NBUSY-1:0] busy_n_i,
  output logic                  busy_n_o,
  output logic                  busy_oe_n_o,
  input  wire logic             mail_irq_n_i,
  output logic                  arbiter_role_select_o
);

  // Register offsets known to the slave
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `DPS_OFF_CTRL) || (a == `DPS_OFF_CMD) || (a == `DPS_OFF_ADDR) ||
                 (a == `DPS_OFF_WDATA) || (a == `DPS_OFF_RDATA) || (a == `DPS_OFF_STATUS);
  endfunction : addr_known

  logic                      role_q;
  logic                      inhibit_q;
  logic [AW-1:0]             addr_q;
  logic [DW-1:0]             wdata_q;
  logic [DW-1:0]             rdata_q;
  dps_host_pkg::host_op_e    op_q;
  dps_host_pkg::main_state_e state_q;
  logic                      step_q;
  logic [2:0]                idx_q;
  logic                      start_q;
  logic                      done_q;
  logic                      grant_q;
  logic                      refused_q;
  logic                      mixed_q;
  logic                      stall_seen_q;

  logic                      wr_fire;
  logic                      rd_fire;
  logic                      cmd_wr;
  logic                      st_wr;
  logic                      fin;
  logic                      seq_sem;
  logic                      seq_write;
  logic [AW-1:0]             seq_addr;
  logic [DW-1:0]             seq_wdata;
  logic                      busy_ok;
  logic                      seq_done;
  logic                      seq_stalled;
  logic [DW-1:0]             seq_rdata;
  logic [31:0]               status_w;

  // Writes complete on the access-phase edge where pready is high; reads are fetched on the setup-phase edge
  assign wr_fire = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_fire = psel_i & ~penable_i & ~pwrite_i;
  assign cmd_wr  = wr_fire & (paddr_i == `DPS_OFF_CMD);
  assign st_wr   = wr_fire & (paddr_i == `DPS_OFF_STATUS);

  // Busy of all stacked devices is ANDed; only the arbitrating role stalls us
  assign busy_ok = role_q ? (&busy_n_i) : 1'b1;

  assign status_w = {25'h0, mixed_q, stall_seen_q, ~mail_irq_n_i, refused_q,
                     grant_q, done_q, (state_q == dps_host_pkg::MS_WAIT)};

  // Fields of the next access, from command, step and loop index
  always_comb begin
    seq_sem   = 1'b0;
    seq_write = 1'b0;
    seq_addr  = addr_q;
    seq_wdata = wdata_q;
    case (op_q)
      dps_host_pkg::OP_MEM_WR: seq_write = 1'b1;
      dps_host_pkg::OP_SEM_CLAIM: begin
        // Write zero then read back; write-then-read avoids contention
        seq_sem   = 1'b1;
        seq_write = ~step_q;
        seq_wdata = '0;
      end
      dps_host_pkg::OP_SEM_RELEASE: begin
        seq_sem   = 1'b1;
        seq_write = 1'b1;
        seq_wdata = {{(DW-1){1'b0}}, 1'b1};
      end
      dps_host_pkg::OP_SEM_READ: seq_sem = 1'b1;
      dps_host_pkg::OP_SEM_INIT: begin
        seq_sem   = 1'b1;
        seq_write = 1'b1;
        seq_addr  = {{(AW-3){1'b0}}, idx_q};
        seq_wdata = {{(DW-1){1'b0}}, 1'b1};
      end
      dps_host_pkg::OP_MAIL_SEND: begin
        // Write the far side's mailbox word to raise its flag
        seq_write = 1'b1;
        seq_addr  = IS_LEFT ? `DPS_MBX_TO_RIGHT : `DPS_MBX_TO_LEFT;
      end
      dps_host_pkg::OP_MAIL_TAKE: begin
        // Read own mailbox word, which also clears own flag
        seq_addr = IS_LEFT ? `DPS_MBX_TO_LEFT : `DPS_MBX_TO_RIGHT;
      end
      default: seq_write = 1'b0;
    endcase
  end

  assign fin = seq_done & ~((op_q == dps_host_pkg::OP_SEM_CLAIM) & ~step_q) &
               ~((op_q == dps_host_pkg::OP_SEM_INIT) & (idx_q != `DPS_SEM_LAST));

  // Command engine: one access, or a claim pair, or the eight-word init loop
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= dps_host_pkg::MS_IDLE;
      op_q    <= dps_host_pkg::OP_MEM_RD;
      step_q  <= 1'b0;
      idx_q   <= 3'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        dps_host_pkg::MS_IDLE: begin
          if (cmd_wr) begin
            op_q    <= dps_host_pkg::host_op_e'(pwdata_i[2:0]);
            step_q  <= 1'b0;
            idx_q   <= 3'h0;
            start_q <= 1'b1;
            state_q <= dps_host_pkg::MS_WAIT;
          end
        end
        dps_host_pkg::MS_WAIT: begin
          if (seq_done && !fin) begin
            step_q  <= 1'b1;
            idx_q   <= idx_q + 3'h1;
            start_q <= 1'b1;
          end else if (fin) begin
            state_q <= dps_host_pkg::MS_IDLE;
          end
        end
        default: state_q <= dps_host_pkg::MS_IDLE;
      endcase
    end
  end

  // Result of the finished command
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
      grant_q <= 1'b0;
      mixed_q <= 1'b0;
    end else if (fin) begin
      rdata_q <= seq_rdata;
      if (op_q == dps_host_pkg::OP_SEM_CLAIM || op_q == dps_host_pkg::OP_SEM_READ) begin
        grant_q <= ~seq_rdata[0];
        mixed_q <= ~((&seq_rdata) | ~(|seq_rdata));
      end
    end
  end

  // Sticky flags; a set in the cycle of a clear wins
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_q       <= 1'b0;
      refused_q    <= 1'b0;
      stall_seen_q <= 1'b0;
    end else begin
      done_q       <= fin | (done_q & ~(st_wr & pwdata_i[`DPS_ST_DONE]));
      refused_q    <= (cmd_wr & (state_q != dps_host_pkg::MS_IDLE)) |
                      (refused_q & ~(st_wr & pwdata_i[`DPS_ST_REFUSED]));
      stall_seen_q <= seq_stalled | (stall_seen_q & ~(st_wr & pwdata_i[`DPS_ST_STALLED]));
    end
  end

  // Software-written registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      role_q    <= 1'(`DPS_CTRL_RESET >> `DPS_CTRL_ROLE);
      inhibit_q <= 1'b0;
      addr_q    <= '0;
      wdata_q   <= '0;
    end else if (wr_fire) begin
      if (paddr_i == `DPS_OFF_CTRL) begin
        role_q    <= pwdata_i[`DPS_CTRL_ROLE];
        inhibit_q <= pwdata_i[`DPS_CTRL_INHIBIT];
      end
      if (paddr_i == `DPS_OFF_ADDR) begin
        addr_q <= pwdata_i[AW-1:0];
      end
      if (paddr_i == `DPS_OFF_WDATA) begin
        wdata_q <= pwdata_i[DW-1:0];
      end
    end
  end

  // Role and busy pins; in the inhibit role we drive busy, high unless inhibiting
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      arbiter_role_select_o <= 1'b0;
      busy_oe_n_o           <= 1'b0;
      busy_n_o              <= 1'b1;
    end else begin
      arbiter_role_select_o <= role_q;
      busy_oe_n_o           <= role_q;
      busy_n_o              <= ~inhibit_q;
    end
  end

  // APB answer: pready rises in the access phase, one wait-free cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_known(paddr_i);
      prdata_o  <= 32'h0000_0000;
      if (rd_fire) begin
        case (paddr_i)
          `DPS_OFF_CTRL:   prdata_o <= {30'h0, inhibit_q, role_q};
          `DPS_OFF_CMD:    prdata_o <= {29'h0, op_q};
          `DPS_OFF_ADDR:   prdata_o <= {{(32-AW){1'b0}}, addr_q};
          `DPS_OFF_WDATA:  prdata_o <= {{(32-DW){1'b0}}, wdata_q};
          `DPS_OFF_RDATA:  prdata_o <= {{(32-DW){1'b0}}, rdata_q};
          `DPS_OFF_STATUS: prdata_o <= status_w;
          default:         prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin sequencer; memory access is never gated by semaphore state
  dps_pin_seq #(
    .AW (AW),
    .DW (DW)
  ) u_seq (
    .sys_clk_i        (sys_clk_i),
    .rst_i            (rst_i),
    .start_i          (start_q),
    .sem_i            (seq_sem),
    .write_i          (seq_write),
    .addr_i           (seq_addr),
    .wdata_i          (seq_wdata),
    .busy_ok_i        (busy_ok),
    .dq_i             (dq_i),
    .done_o           (seq_done),
    .rdata_o          (seq_rdata),
    .stalled_o        (seq_stalled),
    .port_select_n_o  (port_select_n_o),
    .sem_select_n_o   (sem_select_n_o),
    .out_enable_n_o   (out_enable_n_o),
    .write_not_read_o (write_not_read_o),
    .byte_en_n_o      (byte_en_n_o),
    .addr_o           (addr_o),
    .dq_o             (dq_o),
    .dq_oe_n_o        (dq_oe_n_o)
  );

endmodule : dps_host_ctrl
`default_nettype wire

/* verif/dps_host_ctrl_checker.sv */
// Assertions on the APB and device pins of one port controller.
// Bound into dps_host_ctrl from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module dps_host_ctrl_checker #(
  parameter int NBUSY = 1,
  parameter int AW    = 12,
  parameter int DW    = 16
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pready_o,
  input wire logic             port_select_n_o,
  input wire logic             sem_select_n_o,
  input wire logic             out_enable_n_o,
  input wire logic             write_not_read_o,
  input wire logic [1:0]       byte_en_n_o,
  input wire logic [AW-1:0]    addr_o,
  input wire logic [DW-1:0]    dq_o,
  input wire logic             dq_oe_n_o,
  input wire logic [NBUSY-1:0] busy_n_i,
  input wire logic             busy_oe_n_o,
  input wire logic             arbiter_role_select_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Strobe active, any select active, all busy lines released
  wire logic strobe;
  wire logic sel_any;
  wire logic busy_ok;
  assign strobe  = !(write_not_read_o && out_enable_n_o);
  assign sel_any = !(port_select_n_o && sem_select_n_o);
  assign busy_ok = &busy_n_i;
  // Bus answer and pin sequencing
  property p_apb_wait; psel_i && !penable_i |=> pready_o; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready missing after setup");
  property p_sem_sel; !sem_select_n_o |-> port_select_n_o; endproperty
  a_sem_sel: assert property (p_sem_sel) else $error("both selects low");
  property p_sem_addr; !sem_select_n_o |-> addr_o[AW-1:3] == '0; endproperty
  a_sem_addr: assert property (p_sem_addr) else $error("semaphore address high bits set");
  property p_sem_data; !sem_select_n_o && !dq_oe_n_o |-> dq_o[DW-1:1] == '0; endproperty
  a_sem_data: assert property (p_sem_data) else $error("semaphore data above bit zero");
  property p_setup; $rose(strobe) |-> $past(sel_any, 3) && $past(addr_o, 3) == addr_o; endproperty
  a_setup: assert property (p_setup) else $error("strobe before address settled");
  property p_strobe_len; $rose(strobe) |-> strobe[*7] ##1 !strobe; endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
  property p_be; byte_en_n_o != 2'h3 |-> strobe; endproperty
  a_be: assert property (p_be) else $error("byte enable outside strobe");
  property p_wr_data; !write_not_read_o |-> !dq_oe_n_o && $stable(dq_o); endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not held");
  property p_busy_wait; $rose(strobe) && arbiter_role_select_o |-> $past(busy_ok) || $past(busy_ok, 2); endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("strobe while busy low");
  property p_role; arbiter_role_select_o && $past(arbiter_role_select_o) |-> busy_oe_n_o; endproperty
  a_role: assert property (p_role) else $error("busy driven in arbiter role");
endmodule : dps_host_ctrl_checker
`default_nettype wire

/* verif/dps_dev_model.sv */
// Behavioural two-port memory seen from its left port: semaphores, mailboxes, busy.
// The right port is worked by tasks that the testbench calls.
`timescale 1ns/10ps
`default_nettype none
module dps_dev_model (
  input  wire logic        port_select_n_i,
  input  wire logic        sem_select_n_i,
  input  wire logic        out_enable_n_i,
  input  wire logic        write_not_read_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        dq_oe_n_i,
  input  wire logic        busy_pin_i,
  input  wire logic        role_i,
  output logic      [15:0] dq_o,
  output logic             busy_n_o,
  output logic             irq_n_o
);
  logic [15:0] mem [4096];
  int          own [8];
  bit   [7:0]  lreq;
  bit   [7:0]  rreq;
  bit          l_irq;
  bit          r_irq;
  bit          r_on;
  logic [11:0] r_addr;
  logic [15:0] last;
  // Power-up tokens are undefined: all start held by the right side
  initial begin
    foreach (own[i]) own[i] = 2;
    rreq = 8'hFF;
    last = 16'h5A5A;
  end
  // Request latch and owner of one semaphore; s is 1 left, 2 right
  task automatic sem_wr(input int s, input int i, input bit b);
    if (s == 1) lreq[i] = !b;
    else rreq[i] = !b;
    if (own[i] == s && b) own[i] = ((s == 1) ? rreq[i] : lreq[i]) ? 3 - s : 0;
    else if (own[i] == 0 && !b) own[i] = s;
  endtask : sem_wr
  function automatic logic [15:0] sem_rd(input int s, input int i);
    return (own[i] == s) ? 16'h0000 : 16'hFFFF;
  endfunction : sem_rd
  task automatic r_sem(input int i, input bit b);
    sem_wr(2, i, b);
  endtask : r_sem
  task automatic r_write(input logic [11:0] a, input logic [15:0] d);
    mem[a] = d;
    if (a == 12'hFFE) l_irq = 1'b1;
  endtask : r_write
  task automatic r_read(input logic [11:0] a, output logic [15:0] d);
    d = mem[a];
    if (a == 12'hFFF) r_irq = 1'b0;
  endtask : r_read
  // Left writes land once the strobe has settled
  always @(negedge write_not_read_i) begin
    #1;
    if (!sem_select_n_i && !dq_oe_n_i) sem_wr(1, addr_i[2:0], dq_i[0]);
    else if (!port_select_n_i && !dq_oe_n_i && busy_pin_i) begin
      mem[addr_i] = dq_i;
      if (addr_i == 12'hFFF) r_irq = 1'b1;
    end
  end
  // Left read of its mailbox clears its flag
  always @(negedge out_enable_n_i) begin
    if (!port_select_n_i && addr_i == 12'hFFE) l_irq = 1'b0;
  end
  // Keep the last word shown so a released bus shows its inverse
  always @(posedge out_enable_n_i) last = dq_o;
  // Read data, busy toward the left port, and its mailbox flag
  assign dq_o     = out_enable_n_i ? ~last : !sem_select_n_i ? {16{own[addr_i[2:0]] != 1}}
                  : !port_select_n_i ? mem[addr_i] : ~last;
  assign busy_n_o = !(role_i && r_on && !port_select_n_i && addr_i == r_addr);
  assign irq_n_o  = !l_irq;
endmodule : dps_dev_model
`default_nettype wire

/* verif/dps_host_ctrl_tb.sv */
// Top testbench: APB master, device model on the left port, right port by task calls.
// Assumes the controller is the left port of the device.
`timescale 1ns/10ps
`default_nettype none
module dps_host_ctrl_tb;
  logic        sys_clk_i, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, st;
  logic        pready_o, pslverr_o, port_select_n_o, sem_select_n_o, out_enable_n_o, write_not_read_o;
  logic        dq_oe_n_o, busy_n_o, busy_oe_n_o, mail_irq_n_i, arbiter_role_select_o, busy_dev, err;
  logic [1:0]  byte_en_n_o;
  logic [11:0] addr_o, a;
  logic [15:0] dq_i, dq_o, d, got;
  logic [0:0]  busy_n_i;
  logic [15:0] ref_mem [int];
  int          n_mismatch = 0, n_tests = 0, seed = 70;
  int          acts [8] = '{0, 2, 1, 0, 3, 1, 2, 3};
  bit   [7:0]  lg = 8'h13, rf = 8'hB3;
  // Busy pin level from both parties' drivers
  assign busy_n_i = !busy_oe_n_o ? busy_n_o : (arbiter_role_select_o ? busy_dev : 1'b1);
  dps_host_ctrl #(.IS_LEFT(1'b1), .NBUSY(1), .AW(12), .DW(16)) dps_host_ctrl_inst (.sys_clk_i, .rst_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .port_select_n_o,
    .sem_select_n_o, .out_enable_n_o, .write_not_read_o, .byte_en_n_o, .addr_o, .dq_i, .dq_o, .dq_oe_n_o,
    .busy_n_i, .busy_n_o, .busy_oe_n_o, .mail_irq_n_i, .arbiter_role_select_o);
  dps_dev_model dev_inst (.port_select_n_i(port_select_n_o), .sem_select_n_i(sem_select_n_o),
    .out_enable_n_i(out_enable_n_o), .write_not_read_i(write_not_read_o), .addr_i(addr_o), .dq_i(dq_o),
    .dq_oe_n_i(dq_oe_n_o), .busy_pin_i(busy_n_i[0]), .role_i(arbiter_role_select_o), .dq_o(dq_i),
    .busy_n_o(busy_dev), .irq_n_o(mail_irq_n_i));
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input bit w, input logic [7:0] ad, input logic [31:0] wd);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= ad;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb
  // Poll for completion, keep the status, clear sticky bits
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      apb(0, 8'h14, 0);
      k++;
    end while (rd[1] !== 1'b1 && k < 200);
    st = rd;
    chk("done", 1, rd[1]);
    apb(1, 8'h14, 32'h2A);
  endtask : wait_done
  task automatic cmd(input dps_host_pkg::host_op_e op);
    apb(1, 8'h04, 32'(op));
    wait_done();
  endtask : cmd
  task automatic mem_w(input logic [11:0] ad, input logic [15:0] wd);
    apb(1, 8'h08, {20'h0, ad});
    apb(1, 8'h0C, {16'h0, wd});
    cmd(dps_host_pkg::OP_MEM_WR);
  endtask : mem_w
  task automatic mem_r(input logic [11:0] ad);
    apb(1, 8'h08, {20'h0, ad});
    cmd(dps_host_pkg::OP_MEM_RD);
    apb(0, 8'h10, 0);
    chk("mem rdata", {16'h0, ref_mem[ad]}, rd);
  endtask : mem_r
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(0, 8'h00, 0);
    chk("ctrl reset", 0, rd);
    apb(0, 8'h14, 0);
    chk("status reset", 0, rd);
    apb(1, 8'h18, 32'hFFFF);
    chk("unmapped slverr", 1, err);
    // Free all tokens from both sides, then walk the procurement table on each semaphore
    for (int i = 0; i < 8; i++) dev_inst.r_sem(i, 1'b1);
    cmd(dps_host_pkg::OP_SEM_INIT);
    for (int sx = 0; sx < 8; sx++) begin
      a = 12'($random(seed));
      apb(1, 8'h08, {20'h0, a[11:3], 3'(sx)});
      for (int s = 0; s < 8; s++) begin
        if (acts[s] == 0) cmd(dps_host_pkg::OP_SEM_CLAIM);
        else if (acts[s] == 1) cmd(dps_host_pkg::OP_SEM_RELEASE);
        else dev_inst.r_sem(sx, acts[s] == 3);
        cmd(dps_host_pkg::OP_SEM_READ);
        apb(0, 8'h10, 0);
        chk("grant", lg[s], st[2]);
        chk("sem rdata", lg[s] ? 32'h0 : 32'hFFFF, rd);
        chk("sem mixed", 0, st[6]);
        chk("far flag", rf[s] ? 32'hFFFF : 32'h0, dev_inst.sem_rd(2, sx));
      end
    end
    // Plain memory, mailbox word included, while the right side holds a token
    dev_inst.r_sem(0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      a = (i == 3) ? 12'hFFE : 12'($random(seed)) & 12'h7FF;
      d = 16'($random(seed));
      ref_mem[a] = d;
      mem_w(a, d);
      mem_r(a);
    end
    // Mailboxes in both directions
    apb(1, 8'h0C, {16'h0, ~d});
    cmd(dps_host_pkg::OP_MAIL_SEND);
    chk("far irq set", 1, dev_inst.r_irq);
    dev_inst.r_read(12'hFFF, got);
    chk("far mailbox", {16'h0, ~d}, {16'h0, got});
    chk("far irq clear", 0, dev_inst.r_irq);
    dev_inst.r_write(12'hFFE, ~d);
    ref_mem[12'hFFE] = ~d;
    apb(0, 8'h14, 0);
    chk("mail pending", 1, rd[4]);
    cmd(dps_host_pkg::OP_MAIL_TAKE);
    apb(0, 8'h14, 0);
    chk("mail cleared", 0, rd[4]);
    apb(0, 8'h10, 0);
    chk("mail word", {16'h0, ~d}, rd);
    // Arbiter role: a right access on the same word stalls the write; a second order is refused
    a = 12'($random(seed)) & 12'h7FF;
    d = 16'($random(seed));
    dev_inst.r_addr <= a;
    dev_inst.r_on <= 1'b1;
    apb(1, 8'h00, 32'h1);
    apb(1, 8'h08, {20'h0, a});
    apb(1, 8'h0C, {16'h0, d});
    apb(1, 8'h04, 32'(dps_host_pkg::OP_MEM_WR));
    apb(1, 8'h04, 32'(dps_host_pkg::OP_MEM_RD));
    apb(0, 8'h14, 0);
    apb(0, 8'h14, 0);
    chk("stall status", 32'h29, rd & 32'h2B);
    dev_inst.r_on <= 1'b0;
    wait_done();
    ref_mem[a] = d;
    mem_r(a);
    // Inhibit role: held-low busy blocks the write; a collision alone neither stalls nor blocks
    dev_inst.r_on <= 1'b1;
    apb(1, 8'h00, 32'h2);
    mem_w(a, ~d);
    mem_r(a);
    apb(1, 8'h00, 32'h0);
    mem_w(a, ~d);
    ref_mem[a] = ~d;
    mem_r(a);
    dev_inst.r_on <= 1'b0;
    results();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_mismatch++;
    results();
  end
endmodule : dps_host_ctrl_tb
bind dps_host_ctrl dps_host_ctrl_checker #(.NBUSY(NBUSY), .AW(AW), .DW(DW)) chk_inst (.sys_clk_i, .rst_i,
  .psel_i, .penable_i, .pready_o, .port_select_n_o, .sem_select_n_o, .out_enable_n_o, .write_not_read_o,
  .byte_en_n_o, .addr_o, .dq_o, .dq_oe_n_o, .busy_n_i, .busy_oe_n_o, .arbiter_role_select_o);
`default_nettype wire
